// ### ccpu_unit.sv
// Purpose: Capture/compare/PWM unit with AXI4-Lite register access
// Assumes: 25 MHz aclk; timers and A/D live outside; pin comes in asynchronously
// Notes: PWM waveform generation beyond duty compare is kept minimal
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ccpu_cfg.svh"
module ccpu_unit (
   input wire logic aclk, // Clock, 25 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [9:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [9:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire ccpu_pkg::ccpu_timers_s timers, // Timer counts from the same clock
   input wire logic [13:0] config_word, // Non-volatile configuration word
   input wire logic adc_enabled, // A/D converter is on
   input wire logic port_b_pin2_in, // Pin level, port B pin 2
   input wire logic port_b_pin3_in, // Pin level, port B pin 3
   output logic port_b_pin2_out, // Unit output onto port B pin 2
   output logic port_b_pin3_out, // Unit output onto port B pin 3
   output logic timer_16bit_clear, // Pulse clearing the 16-bit timer
   output logic adc_start, // Pulse starting an A/D conversion
   output logic irq // Level interrupt
);
   logic [7:0] value_low;
   logic [7:0] value_high;
   ccpu_pkg::ccpu_ctrl_s ctrl;
   logic unit_irq_flag;
   logic irq_enable;
   logic out_latch;
   logic unit_pin_location;
   logic cap_event;
   logic match_seen;
   logic aw_held;
   logic w_held;
   logic [9:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Mode decode shared by several paths
   function automatic ccpu_pkg::ccpu_class_e mode_class(input logic [3:0] m);
      if (m[3:2] == 2'b11)
         return ccpu_pkg::CCPU_PWM;
      else if (m[3:2] == 2'b10)
         return ccpu_pkg::CCPU_COMPARE;
      else if (m[3:2] == 2'b01)
         return ccpu_pkg::CCPU_CAPTURE;
      return ccpu_pkg::CCPU_OFF;
   endfunction : mode_class

   wire ccpu_pkg::ccpu_class_e cls = mode_class(ctrl.mode);
   wire capture_on = (cls == ccpu_pkg::CCPU_CAPTURE);
   wire compare_on = (cls == ccpu_pkg::CCPU_COMPARE);
   wire pwm_on = (cls == ccpu_pkg::CCPU_PWM);
   wire [15:0] value = {value_high, value_low};

   // Pin location is registered every cycle from config bit 12
   always_ff @(posedge aclk)
   begin
      unit_pin_location <= config_word[`CCPU_PIN_LOC_BIT];
   end
   wire pin_raw = unit_pin_location ? port_b_pin3_in : port_b_pin2_in;

   ccpu_edge_capture u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(pin_raw),
      .capture_on(capture_on),
      .sel(ctrl.mode[1:0]),
      .event_pulse(cap_event)
   );

   // Compare against 16-bit timer, one event per match entry
   wire match_now = compare_on && (timers.count16 == value);
   wire match_event = match_now && !match_seen;
   wire special_event = match_event && (ctrl.mode == 4'hB);
   // PWM duty: 8 high bits in low byte, 2 LSBs from control
   wire [9:0] duty = {value_low, ctrl.duty_low};
   wire pwm_high = {timers.count8, 2'b00} < duty;

   // AXI write channels are taken in either order; address index is byte address / 4
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_go = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wr_idx = aw_addr[9:2];
   wire [7:0] rd_idx = s_axi_araddr[9:2];
   wire wr_lane0 = wr_go && w_strb[0];
   wire wr_vlow = wr_lane0 && (wr_idx == `CCPU_IDX_VALUE_LOW);
   wire wr_vhigh = wr_lane0 && (wr_idx == `CCPU_IDX_VALUE_HIGH);
   wire wr_ctrl = wr_lane0 && (wr_idx == `CCPU_IDX_CONTROL);
   wire wr_clr = wr_lane0 && (wr_idx == `CCPU_IDX_IRQ_CLEAR) && w_data[0];
   wire wr_ena = wr_lane0 && (wr_idx == `CCPU_IDX_IRQ_ENABLE);
   wire wr_ok = (wr_idx >= `CCPU_IDX_VALUE_LOW) && (wr_idx <= `CCPU_IDX_IRQ_ENABLE);
   wire rd_ok = (rd_idx >= `CCPU_IDX_VALUE_LOW) && (rd_idx <= `CCPU_IDX_TIMER8);

   // Write address/data holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 10'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_held <= 1'b0;
         if (w_take)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_go)
            w_held <= 1'b0;
      end
   end

   // Ready while nothing is held; write response follows both halves
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else
      begin
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
         s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read data mux; unused bits read zero
   logic [7:0] rd_byte;
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (rd_idx)
         `CCPU_IDX_VALUE_LOW: rd_byte = value_low;
         `CCPU_IDX_VALUE_HIGH: rd_byte = value_high;
         `CCPU_IDX_CONTROL: rd_byte = {2'b00, ctrl} & `CCPU_CTRL_MASK;
         `CCPU_IDX_IRQ_STATUS: rd_byte = {7'h00, unit_irq_flag};
         `CCPU_IDX_IRQ_ENABLE: rd_byte = {7'h00, irq_enable};
         `CCPU_IDX_TIMER8: rd_byte = timers.count8;
         default: rd_byte = 8'h00;
      endcase
   end
   wire [15:0] rd_half = (rd_idx == `CCPU_IDX_TIMER16) ? timers.count16 : {8'h00, rd_byte};

   // Read channel: one read at a time, answer one cycle after address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_half};
         s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
         s_axi_arready <= !s_axi_arready;
   end

   // Value register: capture overwrites, software writes per byte
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         value_low <= 8'h00;
         value_high <= 8'h00;
      end
      else if (cap_event)
      begin
         value_low <= timers.count16[7:0];
         value_high <= timers.count16[15:8];
      end
      else
      begin
         if (wr_vlow)
            value_low <= w_data[7:0];
         if (wr_vhigh)
            value_high <= w_data[7:0];
      end
   end

   // Control register and enable; reset to zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= ccpu_pkg::ccpu_ctrl_s'(6'(`CCPU_CTRL_RESET));
         irq_enable <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= w_data[5:0];
         if (wr_ena)
            irq_enable <= w_data[0];
      end
   end

   // Sticky flag: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         unit_irq_flag <= 1'b0;
      else if (cap_event || match_event)
         unit_irq_flag <= 1'b1;
      else if (wr_clr)
         unit_irq_flag <= 1'b0;
   end

   // Output latch: compare action, PWM duty, forced low on zero control write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_latch <= 1'b0;
      else if (wr_ctrl && w_data[5:0] == 6'h00)
         out_latch <= 1'b0;
      else if (pwm_on)
         out_latch <= pwm_high;
      else if (match_event && ctrl.mode == 4'h8)
         out_latch <= 1'b1;
      else if (match_event && ctrl.mode == 4'h9)
         out_latch <= 1'b0;
   end

   // Registered outputs and match edge tracking
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         match_seen <= 1'b0;
         timer_16bit_clear <= 1'b0;
         adc_start <= 1'b0;
         irq <= 1'b0;
         port_b_pin2_out <= 1'b0;
         port_b_pin3_out <= 1'b0;
      end
      else
      begin
         match_seen <= match_now;
         timer_16bit_clear <= special_event;
         adc_start <= special_event && adc_enabled;
         irq <= (unit_irq_flag || cap_event || match_event) && irq_enable;
         port_b_pin2_out <= !unit_pin_location && out_latch;
         port_b_pin3_out <= unit_pin_location && out_latch;
      end
   end

   // Assertions
   AST_ADC_NEEDS_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      adc_start |-> $past(adc_enabled) && timer_16bit_clear)
      else $error("A/D start without enabled converter or timer clear");
   AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      (cap_event || match_event) |=> unit_irq_flag)
      else $error("Event did not set the interrupt flag");
   AST_ZERO_CTRL_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && w_data[5:0] == 6'h00) |=> ##1 !port_b_pin2_out && !port_b_pin3_out)
      else $error("Zero control write did not force output low");
   AST_CAPTURE_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_event |=> value == $past(timers.count16))
      else $error("Capture did not copy the timer");
   AST_CTRL_TOP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_axi_rvalid) && $past(rd_idx) == `CCPU_IDX_CONTROL |-> s_axi_rdata[7:0] == {2'b00, $past(ctrl)})
      else $error("Control read did not return the zero-padded control bits");
   AST_CAPTURE_MODE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_event |-> $past(capture_on))
      else $error("Capture event outside capture mode");
   AST_SET_ON_MATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      (match_event && ctrl.mode == 4'h8 && !wr_ctrl) |=> out_latch)
      else $error("Set-on-match did not raise latch");
   AST_PIN_SELECT: assert property (@(posedge aclk) disable iff (!aresetn)
      unit_pin_location |=> !port_b_pin2_out)
      else $error("Wrong pin driven");
endmodule : ccpu_unit
`default_nettype wire

// ### ccpu_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the capture/compare/PWM unit
// Assumes: Included by bare name; definitions only
// Notes: Register offsets are word indices; the AXI4-Lite byte address is four times the index
`ifndef CCPU_CFG_SVH
`define CCPU_CFG_SVH
// Printed offsets are not multiples of four: kept as indices, byte address is four times
`define CCPU_IDX_VALUE_LOW 8'h15
`define CCPU_IDX_VALUE_HIGH 8'h16
`define CCPU_IDX_CONTROL 8'h17
`define CCPU_IDX_IRQ_STATUS 8'h18
`define CCPU_IDX_IRQ_CLEAR 8'h19
`define CCPU_IDX_IRQ_ENABLE 8'h1A
`define CCPU_IDX_TIMER16 8'h1B
`define CCPU_IDX_TIMER8 8'h1C
`define CCPU_CTRL_RESET 8'h00
`define CCPU_CTRL_MASK 8'h3F
`define CCPU_MODE_LSB 0
`define CCPU_DUTY_LSB 4
`define CCPU_PIN_LOC_BIT 12
`define CCPU_PRESC_4 4'h3
`define CCPU_PRESC_16 4'hF
`endif

// ### ccpu_pkg.sv
// Purpose: Types shared by the capture/compare/PWM unit
// Assumes: Constants come from ccpu_cfg.svh
// Notes: Nothing here is imported; uses are scoped
`default_nettype none
package ccpu_pkg;
   typedef enum logic [1:0] {CCPU_OFF, CCPU_CAPTURE, CCPU_COMPARE, CCPU_PWM} ccpu_class_e;
   // Decoded control register
   typedef struct packed {
      logic [1:0] duty_low;
      logic [3:0] mode;
   } ccpu_ctrl_s;
   // Timer side signals
   typedef struct packed {
      logic [15:0] count16;
      logic [7:0] count8;
      logic period_reload;
   } ccpu_timers_s;
endpackage : ccpu_pkg
`default_nettype wire

// ### ccpu_edge_capture.sv
// Purpose: Synchronise the unit pin and produce capture event pulses
// Assumes: Pin is asynchronous to aclk
// Notes: Prescaler clears whenever capture mode is not selected
`timescale 1ns/100ps
`default_nettype none
`include "ccpu_cfg.svh"
module ccpu_edge_capture (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic pin_in, // Raw pin level
   input wire logic capture_on, // Capture mode selected
   input wire logic [1:0] sel, // Low two bits of mode select
   output logic event_pulse // One-cycle capture event
);
   logic sync1;
   logic sync2;
   logic last;
   logic [3:0] presc;
   // Two stage synchroniser; only sync2 feeds logic
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         sync1 <= pin_in;
         sync2 <= sync1;
         last <= sync2;
      end
   end
   wire rise = sync2 & ~last;
   wire fall = ~sync2 & last;
   wire [3:0] limit = sel[0] ? `CCPU_PRESC_16 : `CCPU_PRESC_4;
   wire presc_hit = rise && (presc == limit);
   // Event selection: falling, rising, 4th or 16th rising edge
   wire next_event = capture_on && (sel == 2'b00 ? fall : sel == 2'b01 ? rise : presc_hit);
   // Prescaler counter, cleared outside capture mode
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !capture_on)
         presc <= 4'h0;
      else if (rise)
         presc <= presc_hit ? 4'h0 : presc + 4'h1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         event_pulse <= 1'b0;
      else
         event_pulse <= next_event;
   end
endmodule : ccpu_edge_capture
`default_nettype wire

// ### ccpu_pin_model.sv
// Purpose: Drives the two port B pin inputs of the unit from the outside
// Assumes: The bench sets the level of the pin that the location bit picks
// Notes: The other pin toggles every cycle, so a unit listening there captures junk
`timescale 1ns/100ps
`default_nettype none
module ccpu_pin_model (
   input wire logic aclk, // Clock
   input wire logic level, // Level for the chosen pin
   input wire logic loc, // Pin location bit
   output logic pin2, // Port B pin 2 level
   output logic pin3 // Port B pin 3 level
);
   logic noise = 1'b0;
   // Changing pattern on the unused pin; a stale level could hide a wrong pick
   always_ff @(posedge aclk)
      noise <= !noise;
   // Chosen pin carries the bench level
   assign pin2 = loc ? noise : level;
   assign pin3 = loc ? level : noise;
endmodule : ccpu_pin_model
`default_nettype wire

// ### tb_capture_compare_pwm_unit.sv
// Purpose: Self-checking bench for the capture/compare/PWM unit
// Assumes: Registers over AXI4-Lite; both timers are driven by the bench
// Notes: Pin edges reach the value register a few cycles late, so waits are generous
`timescale 1ns/100ps
`default_nettype none
`include "ccpu_cfg.svh"
module tb_capture_compare_pwm_unit;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] awaddr = 10'h000, araddr = 10'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [15:0] t16 = 16'h0000;
   logic [7:0] t8 = 8'h00;
   logic [13:0] cfg = 14'h0000;
   logic adc_en = 1'b0, level = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pin2, pin3, pin2_out, pin3_out, t_clr, adc_go, irq;
   logic [1:0] bresp, rresp;
   int mismatches = 0, total_checks = 0, n_clr = 0, n_adc = 0;
   ccpu_pin_model pins (.aclk(aclk), .level(level), .loc(cfg[12]), .pin2(pin2), .pin3(pin3));
   ccpu_unit uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timers({t16, t8, 1'b0}),
      .config_word(cfg), .adc_enabled(adc_en), .port_b_pin2_in(pin2), .port_b_pin3_in(pin3),
      .port_b_pin2_out(pin2_out), .port_b_pin3_out(pin3_out), .timer_16bit_clear(t_clr),
      .adc_start(adc_go), .irq(irq));
   initial
      forever #20 aclk = !aclk;
   // Count trigger cycles; a stretched pulse would show as an extra count
   always @(posedge aclk)
   begin
      if (t_clr === 1'b1)
         n_clr <= n_clr + 1;
      if (adc_go === 1'b1)
         n_adc <= n_adc + 1;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         mismatches++;
      end
   endtask : check
   // A handshake that never answers ends the run instead of hanging it
   task automatic bound(input logic ok);
      if (ok !== 1'b1)
      begin
         mismatches++;
         finish_test();
      end
   endtask : bound
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 64);
      bound(bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 64);
      bound(rvalid);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(idx, d, r);
      check(r, 2'b00);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] v;
      logic [1:0] r;
      axi_rd(idx, v, r);
      check(v, {24'h000000, exp});
      check(r, 2'b00);
   endtask : rd
   task automatic pulse;
      level <= 1'b1;
      tick(6);
      level <= 1'b0;
      tick(6);
   endtask : pulse
   // Main sequence: registers, capture, compare, PWM, then pin location and masking
   initial
   begin
      logic [31:0] v;
      logic [1:0] r;
      logic [15:0] e;
      int cnt[4] = '{1, 1, 4, 16};
      logic [3:0] cm[5] = '{4'h8, 4'hA, 4'h9, 4'hB, 4'hB};
      logic ep[3] = '{1'b1, 1'b1, 1'b0};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      tick(3);
      rd(`CCPU_IDX_CONTROL, 8'h00);
      wr(`CCPU_IDX_CONTROL, 8'hFF);
      rd(`CCPU_IDX_CONTROL, 8'h3F);
      axi_rd(8'h00, v, r);
      check(r, 2'b10);
      axi_wr(8'h00, 8'h55, r);
      check(r, 2'b10);
      wr(`CCPU_IDX_VALUE_LOW, 8'hA5);
      wr(`CCPU_IDX_VALUE_HIGH, 8'h3C);
      rd(`CCPU_IDX_VALUE_LOW, 8'hA5);
      rd(`CCPU_IDX_VALUE_HIGH, 8'h3C);
      wr(`CCPU_IDX_IRQ_ENABLE, 8'h01);
      rd(`CCPU_IDX_IRQ_ENABLE, 8'h01);
      // Capture modes; early pulses of a prescaled mode must not capture
      for (int i = 0; i < 4; i++)
      begin
         wr(`CCPU_IDX_CONTROL, 8'h00);
         wr(`CCPU_IDX_CONTROL, 8'h04 + 8'(i));
         wr(`CCPU_IDX_IRQ_CLEAR, 8'h01);
         t16 <= 16'hDEAD;
         repeat (cnt[i] - 1) pulse();
         rd(`CCPU_IDX_IRQ_STATUS, 8'h00);
         e = 16'h5A00 + 16'(i) * 16'h0111;
         t16 <= e;
         pulse();
         rd(`CCPU_IDX_IRQ_STATUS, 8'h01);
         check(irq, 1'b1);
         rd(`CCPU_IDX_VALUE_LOW, e[7:0]);
         rd(`CCPU_IDX_VALUE_HIGH, e[15:8]);
      end
      // Compare actions: set, leave, clear, special event with and without the converter
      wr(`CCPU_IDX_VALUE_LOW, 8'h34);
      wr(`CCPU_IDX_VALUE_HIGH, 8'h12);
      for (int i = 0; i < 5; i++)
      begin
         t16 <= 16'h1200;
         adc_en <= (i == 3);
         wr(`CCPU_IDX_CONTROL, {4'h0, cm[i]});
         wr(`CCPU_IDX_IRQ_CLEAR, 8'h01);
         tick(2);
         check(irq, 1'b0);
         t16 <= 16'h1234;
         tick(6);
         if (i < 3)
            check(pin2_out, ep[i]);
         rd(`CCPU_IDX_IRQ_STATUS, 8'h01);
      end
      check(n_clr, 2);
      check(n_adc, 1);
      // PWM against the 8-bit timer; duty low bits sit below the value byte
      wr(`CCPU_IDX_VALUE_LOW, 8'h40);
      t8 <= 8'h40;
      for (int m = 12; m < 16; m++)
      begin
         wr(`CCPU_IDX_CONTROL, 8'h30 + 8'(m));
         tick(4);
         check(pin2_out, 1'b1);
      end
      wr(`CCPU_IDX_CONTROL, 8'h0C);
      tick(4);
      check(pin2_out, 1'b0);
      t8 <= 8'h3F;
      tick(4);
      check(pin2_out, 1'b1);
      wr(`CCPU_IDX_CONTROL, 8'h00);
      tick(4);
      check(pin2_out, 1'b0);
      // Other pin location, interrupt masked; the value register now holds 16'h1240
      cfg <= 14'h1000;
      wr(`CCPU_IDX_IRQ_ENABLE, 8'h00);
      t16 <= 16'h1200;
      wr(`CCPU_IDX_CONTROL, 8'h08);
      wr(`CCPU_IDX_IRQ_CLEAR, 8'h01);
      t16 <= 16'h1240;
      tick(6);
      check(pin3_out, 1'b1);
      check(pin2_out, 1'b0);
      rd(`CCPU_IDX_IRQ_STATUS, 8'h01);
      check(irq, 1'b0);
      wr(`CCPU_IDX_CONTROL, 8'h00);
      wr(`CCPU_IDX_CONTROL, 8'h05);
      wr(`CCPU_IDX_IRQ_CLEAR, 8'h01);
      t16 <= 16'hBEEF;
      tick(8);
      rd(`CCPU_IDX_IRQ_STATUS, 8'h00);
      pulse();
      rd(`CCPU_IDX_VALUE_LOW, 8'hEF);
      rd(`CCPU_IDX_VALUE_HIGH, 8'hBE);
      axi_rd(`CCPU_IDX_TIMER16, v, r);
      check(v, 32'h0000BEEF);
      rd(`CCPU_IDX_TIMER8, 8'h3F);
      // Codes one to three keep the unit off, so a pin edge captures nothing
      wr(`CCPU_IDX_CONTROL, 8'h03);
      wr(`CCPU_IDX_IRQ_CLEAR, 8'h01);
      pulse();
      rd(`CCPU_IDX_IRQ_STATUS, 8'h00);
      finish_test();
   end
endmodule : tb_capture_compare_pwm_unit
`default_nettype wire
